/* File: pcs_pkg.sv */
package pcs_pkg;

	// widths
	localparam int PC_W      = 15;
	localparam int ADDR_W    = 12;
	localparam int OPERAND_W = 11;
	localparam int SP_W      = 5;
	localparam int STACK_DEPTH = 16;

	// register map (byte wide registers, one location each)
	localparam logic [ADDR_W-1:0] ADDR_PC_LOW_BYTE      = 12'h002;
	localparam logic [ADDR_W-1:0] ADDR_PC_HIGH_LATCH    = 12'h00a;
	localparam logic [ADDR_W-1:0] ADDR_UNIMPL_LO_FIRST  = 12'hf8c;
	localparam logic [ADDR_W-1:0] ADDR_UNIMPL_LO_LAST   = 12'hfe3;
	localparam logic [ADDR_W-1:0] ADDR_STATUS_SHADOW    = 12'hfe4;
	localparam logic [ADDR_W-1:0] ADDR_WORKING_SHADOW   = 12'hfe5;
	localparam logic [ADDR_W-1:0] ADDR_BANK_SHADOW      = 12'hfe6;
	localparam logic [ADDR_W-1:0] ADDR_LATCH_SHADOW     = 12'hfe7;
	localparam logic [ADDR_W-1:0] ADDR_PTR0_LOW_SHADOW  = 12'hfe8;
	localparam logic [ADDR_W-1:0] ADDR_PTR0_HIGH_SHADOW = 12'hfe9;
	localparam logic [ADDR_W-1:0] ADDR_PTR1_LOW_SHADOW  = 12'hfea;
	localparam logic [ADDR_W-1:0] ADDR_PTR1_HIGH_SHADOW = 12'hfeb;
	localparam logic [ADDR_W-1:0] ADDR_UNIMPL_GAP       = 12'hfec;
	localparam logic [ADDR_W-1:0] ADDR_STACK_POINTER    = 12'hfed;
	localparam logic [ADDR_W-1:0] ADDR_STACK_TOP_LOW    = 12'hfee;
	localparam logic [ADDR_W-1:0] ADDR_STACK_TOP_HIGH   = 12'hfef;

	// values after reset
	localparam logic [PC_W-1:0] PC_RESET          = 15'h0000;
	localparam logic [6:0]      LATCH_RESET       = 7'h00;
	localparam logic [SP_W-1:0] STACK_PTR_RESET   = 5'h1f;
	localparam logic [7:0]      READ_ZERO         = 8'h00;

	typedef enum logic [3:0] {
		OP_STEP,
		OP_ADD_W_TO_PCL,
		OP_GOTO,
		OP_CALL,
		OP_COMPUTED_CALL_W,
		OP_BRANCH_RELATIVE_W,
		OP_BRANCH_RELATIVE_IMM,
		OP_RETURN,
		OP_RETURN_INT,
		OP_INT_ENTRY
	} pcs_op_type;

	typedef struct packed {
		pcs_op_type             op;
		logic [OPERAND_W-1:0]   operand;
	} pcs_instr_type;

	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [7:0]        wdata;
	} pcs_bus_req_type;

	// core context saved on interrupt entry (latch is held inside the sequencer)
	typedef struct packed {
		logic [2:0]  status;
		logic [7:0]  working;
		logic [4:0]  bank_select;
		logic [15:0] pointer0;
		logic [15:0] pointer1;
	} pcs_context_type;

endpackage

/* File: pcs_sequencer.sv */
// Operation
// - the program counter is fifteen bits wide and addresses program memory directly.
// - software reads and writes the pc low byte; the upper bits come only from the latch.
// - every reset clears all program counter bits.
// - writing the pc low byte loads the upper bits from the latch in the same step.
// - a computed jump adds W to the pc low byte without carry and takes the upper bits from the latch.
// - an absolute call loads low byte and three high bits from the operand, four from the latch.
// - a computed call loads the low byte from W and the high bits from the latch.
// - a branch by W loads the incremented pc plus W taken as unsigned.
// - a branch by immediate loads the incremented pc plus the signed operand.
// - both branch forms add over all fifteen bits and may cross a 256-location block.
// - shadow copies of flags, W, bank, latch and both pointers sit at consecutive locations.
// - unimplemented core map locations read as zero and ignore writes.
// - after reset the stack is empty with the stack pointer at 0x1f.
// - a push increments the pointer then stores; a pop reloads the pc then decrements.
// - the return stack holds sixteen fifteen-bit entries apart from program and data space.
//
// Implementation choice: the plain strobed port.
`timescale 1ns/100ps
module pcs_sequencer
	import pcs_pkg::*;
#(
	parameter int                 BRA_W      = 9,
	parameter logic [PC_W-1:0]    INT_VECTOR = 15'h0004
) (
	// clock and reset
	input  wire logic            clk_sys,
	input  wire logic            reset,
	// instruction step from the core
	input  wire logic            instr_valid,
	input  wire pcs_instr_type   instr,
	input  wire logic [7:0]      working_register,
	input  wire pcs_context_type context_in,
	// register port
	input  wire pcs_bus_req_type bus_req,
	output logic [7:0]           rd_data,
	// program counter and context restore
	output logic [PC_W-1:0]      pc,
	output pcs_context_type      context_restore,
	output logic                 context_restore_valid
);

	logic [PC_W-1:0]   pc_reg;
	logic [PC_W-1:0]   pc_next;
	logic [6:0]        latch_reg;
	logic [SP_W-1:0]   sp_reg;
	logic [SP_W-1:0]   sp_push;
	logic [PC_W-1:0]   stack_mem [STACK_DEPTH];
	logic [PC_W-1:0]   tos_value;
	logic [PC_W-1:0]   pc_inc;
	logic [PC_W-1:0]   bra_offset;
	logic [PC_W-1:0]   push_value;
	logic [7:0]        addw_low;
	logic              push;
	logic              pop;
	logic              is_op;
	logic [7:0]        rd_value;
	logic [7:0]        rd_data_reg;
	pcs_context_type   restore_reg;
	logic              restore_valid_reg;

	// shadows have no reset: contents survive every reset
	logic [2:0]        status_shadow_reg;
	logic [7:0]        working_shadow_reg;
	logic [4:0]        bank_shadow_reg;
	logic [6:0]        latch_shadow_reg;
	logic [15:0]       ptr0_shadow_reg;
	logic [15:0]       ptr1_shadow_reg;

	// write strobes and interrupt entry/return strobes
	logic wr_pcl;
	logic wr_latch;
	logic wr_sp;
	logic wr_stack_top_low;
	logic wr_stack_top_high;
	logic int_entry;
	logic int_return;

	assign is_op      = instr_valid;
	assign wr_pcl     = bus_req.wr && bus_req.addr == ADDR_PC_LOW_BYTE;
	assign wr_latch   = bus_req.wr && bus_req.addr == ADDR_PC_HIGH_LATCH;
	assign wr_sp      = bus_req.wr && bus_req.addr == ADDR_STACK_POINTER;
	assign wr_stack_top_low    = bus_req.wr && bus_req.addr == ADDR_STACK_TOP_LOW;
	assign wr_stack_top_high    = bus_req.wr && bus_req.addr == ADDR_STACK_TOP_HIGH;
	assign int_entry  = is_op && instr.op == OP_INT_ENTRY;
	assign int_return = is_op && instr.op == OP_RETURN_INT;

	assign pc_inc     = pc_reg + 15'h0001;
	assign addw_low   = pc_reg[7:0] + working_register;
	assign bra_offset = {{(PC_W-BRA_W){instr.operand[BRA_W-1]}}, instr.operand[BRA_W-1:0]};
	assign sp_push    = sp_reg + 5'h01;
	assign tos_value  = stack_mem[sp_reg[3:0]];

	assign push = is_op && (instr.op == OP_CALL || instr.op == OP_COMPUTED_CALL_W
		|| instr.op == OP_INT_ENTRY);
	assign pop  = is_op && (instr.op == OP_RETURN || instr.op == OP_RETURN_INT);
	// an interrupt returns to the instruction it displaced, a call to the next one
	assign push_value = (instr.op == OP_INT_ENTRY) ? pc_reg : pc_inc;

	// next program counter
	always_comb begin
		pc_next = pc_reg;
		if (is_op) begin
			unique case (instr.op)
				OP_STEP:                pc_next = pc_inc;
				OP_ADD_W_TO_PCL:        pc_next = {latch_reg, addw_low};
				OP_GOTO:                pc_next = {latch_reg[6:3], instr.operand};
				OP_CALL:                pc_next = {latch_reg[6:3], instr.operand};
				OP_COMPUTED_CALL_W:     pc_next = {latch_reg, working_register};
				OP_BRANCH_RELATIVE_W:   pc_next = pc_inc + {7'h00, working_register};
				OP_BRANCH_RELATIVE_IMM: pc_next = pc_inc + bra_offset;
				OP_RETURN:              pc_next = tos_value;
				OP_RETURN_INT:          pc_next = tos_value;
				OP_INT_ENTRY:           pc_next = INT_VECTOR;
				default:                pc_next = pc_reg;
			endcase
		end
		// low byte write loads all bits
		if (wr_pcl) begin
			pc_next = {latch_reg, bus_req.wdata};
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			pc_reg <= PC_RESET;
		end else begin
			pc_reg <= pc_next;
		end
	end

	// high-byte latch; restore on interrupt return wins over software
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			latch_reg <= LATCH_RESET;
		end else if (int_return) begin
			latch_reg <= latch_shadow_reg;
		end else if (wr_latch) begin
			latch_reg <= bus_req.wdata[6:0];
		end
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			sp_reg <= STACK_PTR_RESET;
		end else if (push) begin
			sp_reg <= sp_push;
		end else if (pop) begin
			sp_reg <= sp_reg - 5'h01;
		end else if (wr_sp) begin
			sp_reg <= bus_req.wdata[SP_W-1:0];
		end
	end

	// sixteen-entry circular stack; a push past the top overwrites the oldest
	always_ff @(posedge clk_sys) begin
		if (push) begin
			stack_mem[sp_push[3:0]] <= push_value;
		end else if (wr_stack_top_low) begin
			stack_mem[sp_reg[3:0]][7:0] <= bus_req.wdata;
		end else if (wr_stack_top_high) begin
			stack_mem[sp_reg[3:0]][14:8] <= bus_req.wdata[6:0];
		end
	end

	// shadows: entry capture beats a software write
	always_ff @(posedge clk_sys) begin
		if (int_entry) begin
			status_shadow_reg  <= context_in.status;
			working_shadow_reg <= context_in.working;
			bank_shadow_reg    <= context_in.bank_select;
			latch_shadow_reg   <= latch_reg;
			ptr0_shadow_reg    <= context_in.pointer0;
			ptr1_shadow_reg    <= context_in.pointer1;
		end else if (bus_req.wr) begin
			unique case (bus_req.addr)
				ADDR_STATUS_SHADOW:    status_shadow_reg     <= bus_req.wdata[2:0];
				ADDR_WORKING_SHADOW:   working_shadow_reg    <= bus_req.wdata;
				ADDR_BANK_SHADOW:      bank_shadow_reg       <= bus_req.wdata[4:0];
				ADDR_LATCH_SHADOW:     latch_shadow_reg      <= bus_req.wdata[6:0];
				ADDR_PTR0_LOW_SHADOW:  ptr0_shadow_reg[7:0]  <= bus_req.wdata;
				ADDR_PTR0_HIGH_SHADOW: ptr0_shadow_reg[15:8] <= bus_req.wdata;
				ADDR_PTR1_LOW_SHADOW:  ptr1_shadow_reg[7:0]  <= bus_req.wdata;
				ADDR_PTR1_HIGH_SHADOW: ptr1_shadow_reg[15:8] <= bus_req.wdata;
				default: ;
			endcase
		end
	end

	// context handed back on interrupt return
	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			restore_reg       <= '0;
			restore_valid_reg <= 1'b0;
		end else begin
			restore_valid_reg <= int_return;
			if (int_return) begin
				restore_reg.status      <= status_shadow_reg;
				restore_reg.working     <= working_shadow_reg;
				restore_reg.bank_select <= bank_shadow_reg;
				restore_reg.pointer0    <= ptr0_shadow_reg;
				restore_reg.pointer1    <= ptr1_shadow_reg;
			end
		end
	end

	// read decode
	always_comb begin
		rd_value = READ_ZERO;
		unique case (bus_req.addr)
			ADDR_PC_LOW_BYTE:      rd_value = pc_reg[7:0];
			ADDR_PC_HIGH_LATCH:    rd_value = {1'b0, latch_reg};
			ADDR_STATUS_SHADOW:    rd_value = {5'h00, status_shadow_reg};
			ADDR_WORKING_SHADOW:   rd_value = working_shadow_reg;
			ADDR_BANK_SHADOW:      rd_value = {3'h0, bank_shadow_reg};
			ADDR_LATCH_SHADOW:     rd_value = {1'b0, latch_shadow_reg};
			ADDR_PTR0_LOW_SHADOW:  rd_value = ptr0_shadow_reg[7:0];
			ADDR_PTR0_HIGH_SHADOW: rd_value = ptr0_shadow_reg[15:8];
			ADDR_PTR1_LOW_SHADOW:  rd_value = ptr1_shadow_reg[7:0];
			ADDR_PTR1_HIGH_SHADOW: rd_value = ptr1_shadow_reg[15:8];
			ADDR_STACK_POINTER:    rd_value = {3'h0, sp_reg};
			ADDR_STACK_TOP_LOW:    rd_value = tos_value[7:0];
			ADDR_STACK_TOP_HIGH:   rd_value = {1'b0, tos_value[14:8]};
			default:               rd_value = READ_ZERO;
		endcase
	end

	always_ff @(posedge clk_sys or posedge reset) begin
		if (reset) begin
			rd_data_reg <= READ_ZERO;
		end else if (bus_req.rd) begin
			rd_data_reg <= rd_value;
		end else begin
			rd_data_reg <= READ_ZERO;
		end
	end

	assign pc                    = pc_reg;
	assign rd_data               = rd_data_reg;
	assign context_restore       = restore_reg;
	assign context_restore_valid = restore_valid_reg;

	property p_reset_clear;
		// async clear may land after the first sampled edge, so look one cycle on
		@(posedge clk_sys) reset |=> (pc_reg == PC_RESET && sp_reg == STACK_PTR_RESET);
	endproperty
	a_reset_clear: assert property (p_reset_clear) else $error("reset value wrong");

	property p_pcl_write;
		@(posedge clk_sys) disable iff (reset)
		wr_pcl |=> pc_reg == {$past(latch_reg), $past(bus_req.wdata)};
	endproperty
	a_pcl_write: assert property (p_pcl_write) else $error("pcl write not full load");

	property p_addw;
		@(posedge clk_sys) disable iff (reset)
		is_op && instr.op == OP_ADD_W_TO_PCL && !wr_pcl
		|=> pc_reg[7:0] == $past(addw_low) && pc_reg[14:8] == $past(latch_reg);
	endproperty
	a_addw: assert property (p_addw) else $error("computed jump wrong");

	property p_call;
		@(posedge clk_sys) disable iff (reset)
		is_op && instr.op == OP_CALL && !wr_pcl
		|=> pc_reg[10:0] == $past(instr.operand) && pc_reg[14:11] == $past(latch_reg[6:3]);
	endproperty
	a_call: assert property (p_call) else $error("absolute call wrong");

	property p_computed_call_w;
		@(posedge clk_sys) disable iff (reset)
		is_op && instr.op == OP_COMPUTED_CALL_W && !wr_pcl
		|=> pc_reg == {$past(latch_reg), $past(working_register)};
	endproperty
	a_computed_call_w: assert property (p_computed_call_w) else $error("computed call wrong");

	property p_brw;
		@(posedge clk_sys) disable iff (reset)
		is_op && instr.op == OP_BRANCH_RELATIVE_W && !wr_pcl
		|=> pc_reg == PC_W'($past(pc_inc) + {7'h00, $past(working_register)});
	endproperty
	a_brw: assert property (p_brw) else $error("branch by W wrong");

	property p_bra;
		@(posedge clk_sys) disable iff (reset)
		is_op && instr.op == OP_BRANCH_RELATIVE_IMM && !wr_pcl
		|=> pc_reg == PC_W'($past(pc_inc) + $past(bra_offset));
	endproperty
	a_bra: assert property (p_bra) else $error("branch by immediate wrong");

	property p_push;
		@(posedge clk_sys) disable iff (reset)
		push |=> sp_reg == SP_W'($past(sp_reg) + 5'h01) && tos_value == $past(push_value);
	endproperty
	a_push: assert property (p_push) else $error("push order wrong");

	property p_pop;
		@(posedge clk_sys) disable iff (reset)
		pop && !wr_pcl
		|=> pc_reg == $past(tos_value) && sp_reg == SP_W'($past(sp_reg) - 5'h01);
	endproperty
	a_pop: assert property (p_pop) else $error("pop order wrong");

	property p_unimpl;
		@(posedge clk_sys) disable iff (reset)
		bus_req.rd && (bus_req.addr == ADDR_UNIMPL_GAP
		|| (bus_req.addr >= ADDR_UNIMPL_LO_FIRST && bus_req.addr <= ADDR_UNIMPL_LO_LAST))
		|=> rd_data_reg == READ_ZERO;
	endproperty
	a_unimpl: assert property (p_unimpl) else $error("unimplemented read not zero");

	property p_shadow_roundtrip;
		@(posedge clk_sys) disable iff (reset)
		int_return
		|=> context_restore_valid && context_restore.working == $past(working_shadow_reg)
		&& latch_reg == $past(latch_shadow_reg);
	endproperty
	a_shadow_roundtrip: assert property (p_shadow_roundtrip) else $error("context lost");

	// capture must beat any software write in the same cycle
	property p_shadow_capture;
		@(posedge clk_sys) disable iff (reset)
		int_entry
		|=> working_shadow_reg == $past(context_in.working)
		&& status_shadow_reg == $past(context_in.status)
		&& latch_shadow_reg == $past(latch_reg)
		&& ptr1_shadow_reg == $past(context_in.pointer1);
	endproperty
	a_shadow_capture: assert property (p_shadow_capture) else $error("context not saved");

	// interrupt pushes the displaced address, not the next one
	property p_int_entry;
		@(posedge clk_sys) disable iff (reset)
		int_entry && !wr_pcl
		|=> pc_reg == INT_VECTOR && tos_value == $past(pc_reg);
	endproperty
	a_int_entry: assert property (p_int_entry) else $error("interrupt entry wrong");

	property p_step;
		@(posedge clk_sys) disable iff (reset)
		is_op && instr.op == OP_STEP && !wr_pcl
		|=> pc_reg == PC_W'($past(pc_reg) + 15'h0001);
	endproperty
	a_step: assert property (p_step) else $error("step not fifteen bits");

	property p_pc_hold;
		@(posedge clk_sys) disable iff (reset)
		!is_op && !wr_pcl
		|=> $stable(pc_reg);
	endproperty
	a_pc_hold: assert property (p_pc_hold) else $error("pc moved without load");

	property p_rd_pcl;
		@(posedge clk_sys) disable iff (reset)
		bus_req.rd && bus_req.addr == ADDR_PC_LOW_BYTE
		|=> rd_data_reg == $past(pc_reg[7:0]);
	endproperty
	a_rd_pcl: assert property (p_rd_pcl) else $error("pc low byte read wrong");

	property p_latch_write;
		@(posedge clk_sys) disable iff (reset)
		wr_latch && !int_return
		|=> latch_reg == $past(bus_req.wdata[6:0]);
	endproperty
	a_latch_write: assert property (p_latch_write) else $error("latch write lost");

	property p_goto;
		@(posedge clk_sys) disable iff (reset)
		is_op && instr.op == OP_GOTO && !wr_pcl
		|=> pc_reg == {$past(latch_reg[6:3]), $past(instr.operand)};
	endproperty
	a_goto: assert property (p_goto) else $error("absolute jump wrong");

	// a push wins over a same-cycle top write; under a pop the write lands in the entry being popped
	property p_tos_write;
		@(posedge clk_sys) disable iff (reset)
		wr_stack_top_low && !push && !pop
		|=> tos_value[7:0] == $past(bus_req.wdata);
	endproperty
	a_tos_write: assert property (p_tos_write) else $error("stack top write lost");

endmodule

/* File: tb_top.sv */
`timescale 1ns/100ps
module tb_top;
	import pcs_pkg::*;

	localparam logic [PC_W-1:0] VEC = 15'h0004;

	logic            clk_sys;
	logic            reset;
	logic            instr_valid;
	pcs_instr_type   instr;
	logic [7:0]      working_register;
	pcs_context_type context_in;
	pcs_bus_req_type bus_req;
	logic [7:0]      rd_data;
	logic [PC_W-1:0] pc;
	pcs_context_type context_restore;
	logic            context_restore_valid;
	int              error_cnt;
	int              comparisons;

	pcs_sequencer #(.INT_VECTOR(VEC)) pcs_sequencer_inst (
		.clk_sys(clk_sys), .reset(reset), .instr_valid(instr_valid), .instr(instr),
		.working_register(working_register), .context_in(context_in), .bus_req(bus_req),
		.rd_data(rd_data), .pc(pc), .context_restore(context_restore),
		.context_restore_valid(context_restore_valid)
	);

	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	task automatic end_sim;
		if (error_cnt == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
		comparisons++;
		if (g !== e) begin
			$display("wrong value %s expected %h seen %h", nm, e, g);
			error_cnt++;
		end
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk_sys);
		bus_req.wr <= 1'b0;
		#1;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] e, input string nm);
		@(posedge clk_sys);
		bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clk_sys);
		bus_req.rd <= 1'b0;
		#1;
		chk(nm, 48'(e), 48'(rd_data));
	endtask

	task automatic ex(input pcs_op_type op, input logic [10:0] opd, input logic [7:0] w);
		@(posedge clk_sys);
		instr_valid <= 1'b1;
		instr <= '{op: op, operand: opd};
		working_register <= w;
		@(posedge clk_sys);
		instr_valid <= 1'b0;
		#1;
	endtask

	task automatic pc_is(input logic [PC_W-1:0] e);
		chk("pc", 48'(e), 48'(pc));
	endtask

	task automatic t_pc_write;
		chk("pc", 48'(PC_RESET), 48'(pc));
		rd(ADDR_STACK_POINTER, 8'h1f, "stack_pointer");
		wr(ADDR_PC_HIGH_LATCH, 8'hda);
		rd(ADDR_PC_HIGH_LATCH, 8'h5a, "pc_high_latch");
		pc_is(PC_RESET);
		wr(ADDR_PC_LOW_BYTE, 8'h34);
		pc_is({7'h5a, 8'h34});
		rd(ADDR_PC_LOW_BYTE, 8'h34, "pc_low_byte");
		ex(OP_STEP, 11'h000, 8'h00);
		ex(OP_ADD_W_TO_PCL, 11'h000, 8'he0);
		pc_is({7'h5a, 8'h15});
		wr(ADDR_PC_HIGH_LATCH, 8'h7f);
		wr(ADDR_PC_LOW_BYTE, 8'hff);
		ex(OP_STEP, 11'h000, 8'h00);
		pc_is(15'h0000);
	endtask

	task automatic t_calls;
		logic [PC_W-1:0] p;
		wr(ADDR_PC_HIGH_LATCH, 8'h5a);
		wr(ADDR_PC_LOW_BYTE, 8'h10);
		ex(OP_CALL, 11'h7ff, 8'h00);
		pc_is({4'hb, 11'h7ff});
		rd(ADDR_STACK_POINTER, 8'h00, "stack_pointer");
		rd(ADDR_STACK_TOP_LOW, 8'h11, "stack_top_low");
		rd(ADDR_STACK_TOP_HIGH, 8'h5a, "stack_top_high");
		ex(OP_GOTO, 11'h123, 8'h00);
		p = {4'hb, 11'h123};
		pc_is(p);
		ex(OP_COMPUTED_CALL_W, 11'h000, 8'h9c);
		pc_is({7'h5a, 8'h9c});
		rd(ADDR_STACK_POINTER, 8'h01, "stack_pointer");
		ex(OP_RETURN, 11'h000, 8'h00);
		pc_is(p + 15'h0001);
		ex(OP_RETURN, 11'h000, 8'h00);
		pc_is(15'h5a11);
		rd(ADDR_STACK_POINTER, 8'h1f, "stack_pointer");
	endtask

	task automatic t_branch;
		wr(ADDR_PC_HIGH_LATCH, 8'h00);
		wr(ADDR_PC_LOW_BYTE, 8'hfe);
		ex(OP_BRANCH_RELATIVE_W, 11'h000, 8'hff);
		pc_is(15'h01fe);
		wr(ADDR_PC_HIGH_LATCH, 8'h01);
		wr(ADDR_PC_LOW_BYTE, 8'h00);
		ex(OP_BRANCH_RELATIVE_IMM, 11'h1fe, 8'h00);
		pc_is(15'h00ff);
		ex(OP_BRANCH_RELATIVE_IMM, 11'h0ff, 8'h00);
		pc_is(15'h01ff);
	endtask

	task automatic t_context;
		pcs_context_type c;
		logic [7:0]      sh [8];
		c = '{status: 3'h5, working: 8'ha5, bank_select: 5'h13, pointer0: 16'h1234,
			pointer1: 16'h5678};
		sh = '{8'h05, 8'ha5, 8'h13, 8'h33, 8'h34, 8'h12, 8'h78, 8'h56};
		wr(ADDR_PC_HIGH_LATCH, 8'h33);
		wr(ADDR_PC_LOW_BYTE, 8'h40);
		@(posedge clk_sys);
		context_in <= c;
		ex(OP_INT_ENTRY, 11'h000, 8'h00);
		pc_is(VEC);
		for (int i = 0; i < 8; i++) begin
			rd(ADDR_STATUS_SHADOW + 12'(i), sh[i], "shadow");
		end
		wr(ADDR_PC_HIGH_LATCH, 8'h11);
		@(posedge clk_sys);
		context_in <= '0;
		ex(OP_RETURN_INT, 11'h000, 8'h00);
		pc_is(15'h3340);
		chk("restore_valid", 48'h1, 48'(context_restore_valid));
		chk("restore", 48'(c), 48'(context_restore));
		rd(ADDR_PC_HIGH_LATCH, 8'h33, "pc_high_latch");
		chk("restore_valid", 48'h0, 48'(context_restore_valid));
		wr(ADDR_WORKING_SHADOW, 8'h77);
		@(posedge clk_sys);
		reset <= 1'b1;
		repeat (2) @(posedge clk_sys);
		reset <= 1'b0;
		#1;
		pc_is(PC_RESET);
		rd(ADDR_WORKING_SHADOW, 8'h77, "shadow");
		rd(ADDR_PTR1_HIGH_SHADOW, 8'h56, "shadow");
		rd(ADDR_STACK_POINTER, 8'h1f, "stack_pointer");
	endtask

	task automatic t_unmapped;
		logic [ADDR_W-1:0] a [3];
		a = '{ADDR_UNIMPL_LO_FIRST, ADDR_UNIMPL_LO_LAST, ADDR_UNIMPL_GAP};
		for (int i = 0; i < 3; i++) begin
			wr(a[i], 8'hff);
			rd(a[i], READ_ZERO, "unmapped");
		end
	endtask

	// every entry holds its own fifteen bits
	task automatic t_stack;
		for (int i = 0; i < 16; i++) begin
			wr(ADDR_STACK_POINTER, 8'(i));
			wr(ADDR_STACK_TOP_LOW, 8'(i * 17));
			wr(ADDR_STACK_TOP_HIGH, 8'(i + 128));
		end
		for (int i = 0; i < 16; i++) begin
			wr(ADDR_STACK_POINTER, 8'(i));
			rd(ADDR_STACK_TOP_LOW, 8'(i * 17), "stack_top_low");
			rd(ADDR_STACK_TOP_HIGH, 8'(i), "stack_top_high");
		end
	endtask

	// hang guard
	initial begin
		#2000000;
		error_cnt++;
		end_sim();
	end

	initial begin
		error_cnt = 0;
		comparisons = 0;
		reset = 1'b1;
		instr_valid = 1'b0;
		instr = '{op: OP_STEP, operand: 11'h000};
		working_register = 8'h00;
		context_in = '0;
		bus_req = '0;
		repeat (16) @(posedge clk_sys);
		reset <= 1'b0;
		#1;
		t_pc_write();
		t_calls();
		t_branch();
		t_context();
		t_unmapped();
		t_stack();
		end_sim();
	end
endmodule
